// *** verilog/ofc_pkg.sv ***
// Shared constants, types and coding functions of the fuse controller
package ofc_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NW  = 31;
	localparam int NB0 = 7;
	localparam int KWD = 8;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [8:0] A_PROG = 9'h000;
	localparam logic [8:0] P_END  = 9'h07c;
	localparam logic [8:0] A_READ = 9'h080;
	localparam logic [8:0] R_END  = 9'h0fc;
	localparam logic [8:0] A_UNLK = 9'h100;
	localparam logic [8:0] A_CMD  = 9'h104;
	localparam logic [8:0] A_TIM  = 9'h108;
	localparam logic [8:0] A_DAC  = 9'h10c;
	localparam logic [8:0] A_RAW  = 9'h110;
	localparam logic [8:0] A_ST   = 9'h114;
	localparam logic [8:0] A_ENA  = 9'h118;
	localparam logic [8:0] A_CLR  = 9'h11c;
	localparam logic [8:0] A_STAT = 9'h120;

	// ----------------------------------------
	// Codes, fields and reset values
	// ----------------------------------------
	localparam logic [31:0] UNLK_PROG = 32'h0000_5a5a;
	localparam logic [31:0] UNLK_READ = 32'h0000_5aa5;
	localparam logic [31:0] CMD_IDLE  = 32'h0000_0000;
	localparam logic [31:0] CMD_READ  = 32'h0000_0001;
	localparam logic [31:0] CMD_PROG  = 32'h0000_0002;
	localparam logic [31:0] TIM_RST   = 32'h0000_ff50;
	localparam logic [31:0] DAC_RST   = 32'h0000_0028;
	localparam int IRQ_RD  = 0;
	localparam int IRQ_PG  = 1;
	localparam int RDD_LO  = 16;
	localparam int PRES_W  = 3;
	localparam int PRES_B  = 14;
	localparam int CS_W    = 6;
	localparam int SEL0_LO = 0;
	localparam int SEL1_LO = 8;
	localparam int CUT_LO  = 96;
	localparam int CUT_W   = 48;
	localparam logic [1:0] CS_34  = 2'h1;
	localparam logic [1:0] CS_REP = 2'h2;
	// Byte 7 form unconfirmed: 1 checks a byte sum, 0 skips it
	localparam bit CHK7_SUM = 1'b1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_READ} ofc_state_t;

	typedef struct packed {
		logic [8:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} ofc_av_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} ofc_av_rsp_t;

	// ----------------------------------------
	// Key block coding
	// ----------------------------------------
	function automatic logic [255:0] ofc_decode(input logic [255:0] e, input logic [1:0] cs, input logic cut);
		logic [255:0] d;
		d = '0;
		if (cs == CS_34) begin
			for (int i = 0; i < 4; i++) begin
				for (int j = 0; j < 6; j++) begin
					d[48*i+8*j+:8] = e[64*i+8*j+:8];
				end
			end
			if (cut) begin
				d[CUT_LO+:CUT_W] = '0;
			end
		end else if (cs == CS_REP) begin
			d[127:0] = e[127:0];
		end else begin
			d = e;
		end
		return d;
	endfunction

	function automatic logic ofc_chk_ok(input logic [255:0] e);
		logic [7:0] x;
		logic [7:0] s;
		logic       ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			x = '0;
			s = '0;
			for (int j = 0; j < 6; j++) begin
				x = x ^ e[64*i+8*j+:8];
				s = s + e[64*i+8*j+:8];
			end
			if (e[64*i+48+:8] != x) begin
				ok = 1'b0;
			end
			if (CHK7_SUM && e[64*i+56+:8] != s) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

endpackage

// *** verilog/ofc_top.sv ***
// Fuse program and read controller with Avalon-MM register slave
//
// Behaviour
// - Unlocked parameter bits may only go from 0 to 1.
// - A program leaves every bit of a locked parameter unchanged.
// - One lock bit per parameter; the lock field guards itself too.
// - A set write lock can never be cleared.
// - Twenty parameters are always readable by software and hardware.
// - Six parameters, when read-locked, reach hardware only, not software.
// - Read-lock bit 1 protects its parameter permanently.
// - Coding field: 00/11 none, 01 three-quarter, 10 repeat; 256 fuses each.
// - Under none, encoded bits equal logical bits.
// - Three-quarter: six data bytes per group plus XOR byte six.
// - Repeat: 128 logical bits stored in both halves.
// - Partial reserve forces three-quarter and drops third block bits 143:96.
// - Every fuse bit has one program register bit; keys take eight words.
// - On finish the command register returns to zero, done event raised.
// - Program-done bit 1, read-done bit 0; writing 1 clears.
// - Key reads return decoded values; bits past scheme width invalid.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module ofc_top (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	// Register bus
	input  wire ofc_pkg::ofc_av_req_t   av_req,
	output ofc_pkg::ofc_av_rsp_t        av_rsp,
	// Hardware consumers
	output logic [6:0][31:0]            hw_sys,
	output logic [2:0][255:0]           hw_key,
	// Events and state
	output logic                        irq,
	output logic                        busy
);
	import ofc_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [NW-1:0][31:0] prog_ff;
	logic [NW-1:0][31:0] fuse_ff;
	logic [NW-1:0][31:0] rd_ff;
	logic [NW-1:0][31:0] lock_all;
	logic [31:0]         unlk_ff;
	logic [31:0]         cmd_ff;
	logic [31:0]         tim_ff;
	logic [31:0]         dac_ff;
	logic [1:0]          raw_ff;
	logic [1:0]          ena_ff;
	logic [2:0]          err_ff;
	logic [7:0]          cnt_ff;
	logic [7:0]          nxt_cnt;
	ofc_state_t          st;
	logic [2:0][255:0]   enc;
	logic [2:0][255:0]   dec;
	logic [31:0]         rdmux;
	logic                acc;
	logic                wr;
	logic [8:0]          addr;
	logic [4:0]          idx;
	logic                go_prog;
	logic                go_read;
	logic                done_prog;
	logic                done_read;
	logic                pres;
	logic [1:0]          scheme;
	logic [15:0]         wrdis;
	logic [3:0]          rddis;
	logic [1:0]          clr;

	// ----------------------------------------
	// Lock masks
	// ----------------------------------------
	// per-parameter lock map
	function automatic logic [31:0] wr_mask(input logic [4:0] w, input logic [15:0] d);
		logic [31:0] m;
		m = '0;
		case (w)
			5'd0: m = {4'h0, {8{d[2]}}, {4{d[0]}}, {16{d[1]}}};
			5'd1: m = {32{d[3]}};
			5'd2: m = {8'h00, {24{d[3]}}};
			5'd3: m = {17'h0, d[10], 1'b0, {9{d[3]}}, 4'h0};
			5'd4: m = {15'h0, {3{d[5]}}, 14'h0};
			5'd5: m = {{4{d[10]}}, 8'h00, {20{d[6]}}};
			5'd6: m = {21'h0, d[10], {3{d[15]}}, d[14], d[13], d[12], 1'b0, d[15], {2{d[10]}}};
			default: begin
				if (w >= 5'd23) begin
					m = {32{d[9]}};
				end else if (w >= 5'd15) begin
					m = {32{d[8]}};
				end else begin
					m = {32{d[7]}};
				end
			end
		endcase
		return m;
	endfunction

	function automatic logic [31:0] rd_mask(input logic [4:0] w, input logic [3:0] d);
		logic [31:0] m;
		m = '0;
		case (w)
			5'd3: m = {17'h0, d[3], 14'h0};
			5'd5: m = {{4{d[3]}}, 28'h0};
			5'd6: m = {21'h0, d[3], 8'h0, {2{d[3]}}};
			default: begin
				if (w >= 5'd23) begin
					m = {32{d[2]}};
				end else if (w >= 5'd15) begin
					m = {32{d[1]}};
				end else if (w >= 5'd7) begin
					m = {32{d[0]}};
				end
			end
		endcase
		return m;
	endfunction

	// ----------------------------------------
	// Decode and control fields
	// ----------------------------------------
	assign wrdis = fuse_ff[0][15:0];
	assign rddis = fuse_ff[0][RDD_LO+:4];
	assign pres  = fuse_ff[PRES_W][PRES_B];
	assign scheme = pres ? CS_34 : fuse_ff[CS_W][1:0];

	genvar b, k;
	generate
		for (b = 0; b < 3; b++) begin : g_blk
			for (k = 0; k < KWD; k++) begin : g_wd
				assign enc[b][32*k+:32] = fuse_ff[NB0+KWD*b+k];
			end
			assign dec[b] = ofc_decode(enc[b], scheme, (b == 2) && pres);
		end
	endgenerate

	// ----------------------------------------
	// Avalon slave
	// ----------------------------------------
	assign acc  = (av_req.read | av_req.write) & av_rsp.waitrequest;
	// Writes land only at the ready edge, when the master completes the transfer
	assign wr   = av_req.write & ~av_rsp.waitrequest;
	assign addr = av_req.address;
	assign idx  = addr[6:2];

	always_comb begin
		rdmux = '0;
		if (addr < P_END) begin
			rdmux = prog_ff[idx];
		end else if (addr >= A_READ && addr < R_END) begin
			rdmux = rd_ff[idx] & ~rd_mask(idx, rddis);
		end else if (addr == A_UNLK) begin
			rdmux = unlk_ff;
		end else if (addr == A_CMD) begin
			rdmux = cmd_ff;
		end else if (addr == A_TIM) begin
			rdmux = tim_ff;
		end else if (addr == A_DAC) begin
			rdmux = dac_ff;
		end else if (addr == A_RAW) begin
			rdmux = {30'h0, raw_ff};
		end else if (addr == A_ST) begin
			rdmux = {30'h0, raw_ff & ena_ff};
		end else if (addr == A_ENA) begin
			rdmux = {30'h0, ena_ff};
		end else if (addr == A_STAT) begin
			rdmux = {28'h0, busy, err_ff};
		end
	end

	// One wait cycle, then a single ready cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			av_rsp <= '{waitrequest: 1'b1, readdata: 32'h0};
		end else if (acc) begin
			av_rsp.waitrequest <= 1'b0;
			av_rsp.readdata    <= av_req.read ? rdmux : 32'h0;
		end else begin
			av_rsp.waitrequest <= 1'b1;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// software unlock, timing, DAC and enable values
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			unlk_ff <= 32'h0;
			tim_ff  <= TIM_RST;
			dac_ff  <= DAC_RST;
			ena_ff  <= 2'h0;
		end else if (wr) begin
			if (addr == A_UNLK) begin
				unlk_ff <= av_req.writedata;
			end else if (addr == A_TIM) begin
				tim_ff <= {16'h0, av_req.writedata[15:0]};
			end else if (addr == A_DAC) begin
				dac_ff <= {24'h0, av_req.writedata[7:0]};
			end else if (addr == A_ENA) begin
				ena_ff <= av_req.writedata[1:0];
			end
		end
	end

	// ----------------------------------------
	// Command sequencing
	// ----------------------------------------
	// unlock code must match
	assign go_prog = wr && addr == A_CMD && st == ST_IDLE
		&& av_req.writedata == CMD_PROG && unlk_ff == UNLK_PROG;
	assign go_read = wr && addr == A_CMD && st == ST_IDLE
		&& av_req.writedata == CMD_READ && unlk_ff == UNLK_READ;
	assign done_prog = st == ST_PROG && cnt_ff == 8'h01;
	assign done_read = st == ST_READ && cnt_ff == 8'h01;

	// Zero selector would wrap the count and take 256 cycles, so it counts as one
	always_comb begin
		nxt_cnt = go_prog ? tim_ff[SEL1_LO+:8] : tim_ff[SEL0_LO+:8];
		if (nxt_cnt == 8'h00) begin
			nxt_cnt = 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st     <= ST_IDLE;
			cmd_ff <= CMD_IDLE;
			cnt_ff <= 8'h00;
		end else begin
			case (st)
				ST_IDLE: begin
					if (go_prog) begin
						st     <= ST_PROG;
						cmd_ff <= CMD_PROG;
						cnt_ff <= nxt_cnt;
					end else if (go_read) begin
						st     <= ST_READ;
						cmd_ff <= CMD_READ;
						cnt_ff <= nxt_cnt;
					end
				end
				default: begin
					if (cnt_ff == 8'h01) begin
						st     <= ST_IDLE;
						cmd_ff <= CMD_IDLE;
					end
					cnt_ff <= cnt_ff - 8'h01;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= (st == ST_IDLE) ? (go_prog | go_read) : !(cnt_ff == 8'h01);
		end
	end

	// ----------------------------------------
	// Fuse array, program and read shadows
	// ----------------------------------------
	generate
		for (k = 0; k < NW; k++) begin : g_word
			assign lock_all[k] = wr_mask(5'(k), wrdis);

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					prog_ff[k] <= 32'h0;
				end else if (wr && addr < P_END && idx == 5'(k)) begin
					prog_ff[k] <= av_req.writedata;
				end
			end

			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					fuse_ff[k] <= 32'h0;
				end else if (done_prog) begin
					fuse_ff[k] <= fuse_ff[k] | (prog_ff[k] & ~lock_all[k]);
				end
			end

			if (k < NB0) begin : g_sys
				always_ff @(posedge mclk or negedge resetn) begin
					if (!resetn) begin
						rd_ff[k] <= 32'h0;
					end else if (done_read) begin
						rd_ff[k] <= fuse_ff[k];
					end
				end
			end else begin : g_key
				// Split per word kind, so no negative select is ever elaborated
				always_ff @(posedge mclk or negedge resetn) begin
					if (!resetn) begin
						rd_ff[k] <= 32'h0;
					end else if (done_read) begin
						rd_ff[k] <= dec[(k-NB0)/KWD][32*((k-NB0)%KWD)+:32];
					end
				end
			end
		end
	endgenerate

	assign hw_sys = rd_ff[NB0-1:0];
	generate
		for (b = 0; b < 3; b++) begin : g_hw
			assign hw_key[b] = rd_ff[NB0+KWD*b+:KWD];
		end
	endgenerate

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			err_ff <= 3'h0;
		end else if (done_read) begin
			for (int i = 0; i < 3; i++) begin
				err_ff[i] <= (scheme == CS_34) && !ofc_chk_ok(enc[i]);
			end
		end
	end

	// ----------------------------------------
	// Done events
	// ----------------------------------------
	assign clr = (wr && addr == A_CLR) ? av_req.writedata[1:0] : 2'h0;

	// a new event beats the clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			raw_ff <= 2'h0;
			irq    <= 1'b0;
		end else begin
			raw_ff <= (raw_ff & ~clr) | {done_prog, done_read};
			irq    <= |(((raw_ff & ~clr) | {done_prog, done_read}) & ena_ff);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_prog_end;
		st == ST_PROG && cnt_ff == 8'h01;
	endsequence
	sequence s_read_end;
		st == ST_READ && cnt_ff == 8'h01;
	endsequence

	property p_done_prog;
		s_prog_end |=> cmd_ff == CMD_IDLE && raw_ff[IRQ_PG] && st == ST_IDLE;
	endproperty
	a_done_prog: assert property (p_done_prog) else $error("program end not reported");

	property p_done_read;
		s_read_end |=> cmd_ff == CMD_IDLE && raw_ff[IRQ_RD] && !busy;
	endproperty
	a_done_read: assert property (p_done_read) else $error("read end not reported");

	property p_mono;
		($past(fuse_ff) & ~fuse_ff) == '0;
	endproperty
	a_mono: assert property (p_mono) else $error("fuse bit fell");

	property p_locked;
		!$stable(fuse_ff) |-> ((fuse_ff ^ $past(fuse_ff)) & $past(lock_all)) == '0;
	endproperty
	a_locked: assert property (p_locked) else $error("locked bit burned");

	property p_lock_perm;
		$past(wrdis[1]) |-> wrdis[1] && lock_all[0][15:0] == 16'hffff;
	endproperty
	a_lock_perm: assert property (p_lock_perm) else $error("lock field reopened");

	property p_badcmd;
		wr && addr == A_CMD && st == ST_IDLE && !go_prog && !go_read |=> st == ST_IDLE && cmd_ff == CMD_IDLE;
	endproperty
	a_badcmd: assert property (p_badcmd) else $error("locked command ran");

	property p_rdlock;
		acc && av_req.read && addr >= 9'h09c && addr < 9'h0bc && rddis[0] |=> av_rsp.readdata == 32'h0;
	endproperty
	a_rdlock: assert property (p_rdlock) else $error("protected key leaked");

	property p_bus;
		acc |=> !av_rsp.waitrequest ##1 av_rsp.waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer timing wrong");

	property p_clr;
		wr && addr == A_CLR && av_req.writedata[IRQ_RD] && !done_read |=> !raw_ff[IRQ_RD];
	endproperty
	a_clr: assert property (p_clr) else $error("done clear ignored");

	property p_repeat;
		s_read_end and (scheme == CS_REP) |=> rd_ff[14:11] == '0 && rd_ff[10:7] == $past(fuse_ff[10:7]);
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat decode wrong");

endmodule // ofc_top

// *** dv/tb_top.sv ***
// Self-checking bench for the fuse program and read controller
`timescale 1ns/100ps
module tb_top;
	import ofc_pkg::*;

	logic              mclk;
	logic              resetn;
	ofc_av_req_t       av_req;
	ofc_av_rsp_t       av_rsp;
	logic [6:0][31:0]  hw_sys;
	logic [2:0][255:0] hw_key;
	logic              irq;
	logic              busy;
	int                err_count = 0;
	int                num_checks = 0;
	int                cyc_ff = 0;
	logic [31:0]       rd;

	ofc_top DUT (.mclk(mclk), .resetn(resetn), .av_req(av_req), .av_rsp(av_rsp),
		.hw_sys(hw_sys), .hw_key(hw_key), .irq(irq), .busy(busy));

	// ----------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	// Whole run needs roughly 4k cycles
	always @(posedge mclk) begin
		cyc_ff <= cyc_ff + 1;
		if (cyc_ff == 40000) begin
			err_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	// Raise one edge after entry, so a release is never overwritten in its own time step
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		av_req <= '{address: a, read: ~w, write: w, writedata: d};
		do begin
			@(posedge mclk);
			n++;
		end while (av_rsp.waitrequest !== 1'b0 && n < 50);
		q = av_rsp.readdata;
		av_req <= '0;
		if (n == 50) chk(32'h1, 32'h0);
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, exp);
	endtask

	function automatic logic [8:0] pa(input int k);
		return A_PROG + 9'(4 * k);
	endfunction

	function automatic logic [8:0] ra(input int k);
		return A_READ + 9'(4 * k);
	endfunction

	task automatic op(input logic [31:0] cmd);
		int n;
		n = 0;
		wr(A_UNLK, (cmd == CMD_PROG) ? UNLK_PROG : UNLK_READ);
		wr(A_CMD, cmd);
		rdc(A_CMD, cmd);
		chk({31'h0, busy}, 32'h1);
		while (rd !== CMD_IDLE && n < 400) begin
			bus(1'b0, A_CMD, 32'h0, rd);
			n++;
		end
		chk(rd, CMD_IDLE);
	endtask

	task automatic burn(input int k, input logic [31:0] d);
		wr(pa(k), d);
		op(CMD_PROG);
		op(CMD_READ);
		wr(pa(k), 32'h0);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdc(A_TIM, TIM_RST);
		rdc(A_DAC, DAC_RST);
		rdc(A_CMD, CMD_IDLE);
		rdc(9'h1fc, 32'h0);
		wr(pa(5), 32'h1234_5678);
		rdc(pa(5), 32'h1234_5678);
		wr(pa(5), 32'h0);
		wr(A_TIM, {16'h0, 8'd128, 8'd80});
		wr(A_DAC, 32'd160);
		rdc(A_TIM, 32'h0000_8050);
		rdc(A_DAC, 32'h0000_00a0);
	endtask

	task automatic t_refuse();
		wr(pa(2), 32'h0000_00ff);
		wr(A_UNLK, UNLK_READ);
		wr(A_CMD, CMD_PROG);
		rdc(A_CMD, CMD_IDLE);
		chk({31'h0, busy}, 32'h0);
		wr(A_UNLK, 32'h0);
		wr(A_CMD, CMD_READ);
		rdc(A_CMD, CMD_IDLE);
		wr(pa(2), 32'h0);
		op(CMD_READ);
		rdc(ra(2), 32'h0);
	endtask

	task automatic t_prog();
		wr(A_CLR, 32'h3);
		wr(A_ENA, 32'h3);
		wr(pa(1), 32'h0000_00f0);
		op(CMD_PROG);
		rdc(A_RAW, 32'h2);
		rdc(A_ST, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(A_CLR, 32'h2);
		rdc(A_RAW, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(A_ENA, 32'h1);
		op(CMD_READ);
		rdc(A_ST, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdc(ra(1), 32'h0000_00f0);
		chk(hw_sys[1], 32'h0000_00f0);
		wr(A_CLR, 32'h1);
		wr(pa(1), 32'h0000_000f);
		op(CMD_PROG);
		rdc(A_RAW, 32'h2);
		rdc(A_ST, 32'h0);
		chk({31'h0, irq}, 32'h0);
		op(CMD_READ);
		rdc(ra(1), 32'h0000_00ff);
		wr(pa(1), 32'h0);
		wr(A_CLR, 32'h3);
	endtask

	task automatic t_lock();
		burn(0, 32'h0000_0008);
		burn(1, 32'h0000_ff00);
		rdc(ra(1), 32'h0000_00ff);
		burn(0, 32'h0000_0002);
		burn(0, 32'h0000_0010);
		rdc(ra(0), 32'h0000_000a);
	endtask

	task automatic t_codes();
		burn(7, 32'ha5a5_1234);
		rdc(ra(7), 32'ha5a5_1234);
		chk(hw_key[0][31:0], 32'ha5a5_1234);
		burn(6, 32'h0000_0001);
		// Key two valid group, key three with a wrong XOR byte
		wr(pa(16), 32'h1507_0605);
		wr(pa(23), 32'h0403_0201);
		wr(pa(24), 32'h1500_0605);
		burn(15, 32'h0403_0201);
		wr(pa(16), 32'h0);
		wr(pa(23), 32'h0);
		wr(pa(24), 32'h0);
		rdc(ra(15), 32'h0403_0201);
		rdc(ra(16), 32'h0000_0605);
		chk(hw_key[1][47:16], 32'h0605_0403);
		rdc(A_STAT, 32'h0000_0005);
		burn(6, 32'h0000_0002);
		rdc(ra(16), 32'h1507_0605);
	endtask

	task automatic t_rep();
		rdc(ra(1), 32'h0);
		burn(6, 32'h0000_0002);
		wr(pa(11), 32'hdead_beef);
		burn(7, 32'hdead_beef);
		wr(pa(11), 32'h0);
		rdc(ra(7), 32'hdead_beef);
		rdc(ra(11), 32'h0);
		chk(hw_key[0][31:0], 32'hdead_beef);
		burn(0, 32'h0001_0000);
		rdc(ra(7), 32'h0);
		chk(hw_key[0][31:0], 32'hdead_beef);
		rdc(ra(0), 32'h0001_0000);
	endtask

	task automatic t_res();
		wr(pa(27), 32'hffff_ffff);
		wr(pa(11), 32'hffff_ffff);
		burn(3, 32'h0000_4000);
		rdc(ra(26), 32'h0);
		rdc(ra(27), 32'h0);
		wr(pa(27), 32'h0);
		wr(pa(11), 32'h0);
		rdc(ra(10), 32'hffff_ffff);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		av_req = '0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_refuse();
		t_prog();
		t_lock();
		t_codes();
		do_reset();
		t_rep();
		do_reset();
		t_res();
		results();
	end

endmodule // tb_top
